// File: design/timer_pkg.sv
// Constants, field layouts and carrier types for the compact timer
package timer_pkg;

    // Register bus and field widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;
    localparam int PERIOD_W = 3;
    localparam int LEN_W = 11;

    // Register offsets (byte registers on the plain port)
    localparam logic [2:0] ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
    localparam logic [2:0] ADDR_CMP_A_LOW = 3'h4;
    localparam logic [2:0] ADDR_CMP_A_HIGH = 3'h5;
    localparam logic [2:0] ADDR_FLAGS = 3'h6;

    // Reset values and field helpers
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] HIGH_UNUSED_MASK = 8'hFC;
    localparam logic [5:0] HIGH_PAD = 6'h00;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] COUNT_MAX = 10'h3FF;
    localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 3'h0;
    localparam logic [6:0] PERIOD_LOW_ZERO = 7'h00;
    localparam logic [LEN_W-1:0] FULL_PERIOD = 11'h400;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    // Operating modes
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_UNDEF = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;

    // Pin actions, compare mode and PWM mode
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] ACT_FORCE_INACTIVE = 2'h0;
    localparam logic [1:0] ACT_FORCE_ACTIVE = 2'h1;
    localparam logic [1:0] ACT_WAVEFORM = 2'h2;

    // Counter clock selections
    localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CKS_SYS = 3'h1;
    localparam logic [2:0] CKS_FAST_DIV16 = 3'h2;
    localparam logic [2:0] CKS_FAST_DIV64 = 3'h3;
    localparam logic [2:0] CKS_SUB_A = 3'h4;
    localparam logic [2:0] CKS_SUB_B = 3'h5;
    localparam logic [2:0] CKS_EXT_RISE = 3'h6;
    localparam logic [2:0] CKS_EXT_FALL = 3'h7;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0F;
    localparam logic [5:0] DIV64_MASK = 6'h3F;
    localparam logic [5:0] PRESCALE_ONE = 6'h01;

    // Sub clock emulated from the system clock
    localparam int SYS_CLOCK_HZ = 50_000_000;
    localparam int SUB_CLOCK_HZ = 32_768;
    localparam int SUB_DIV = SYS_CLOCK_HZ / SUB_CLOCK_HZ;
    localparam logic [10:0] SUB_LAST = 11'(SUB_DIV - 1);
    localparam logic [10:0] SUB_ZERO = 11'h000;
    localparam logic [10:0] SUB_ONE = 11'h001;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // First control register, bit 7 first
    typedef struct packed {
        logic pause;
        logic [2:0] clock_select;
        logic module_enable;
        logic [PERIOD_W-1:0] period_compare_value;
    } ctrl0_s;

    // Second control register, bit 7 first
    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
        logic pin_action_hi;
        logic pin_action_lo;
        logic output_initial_level;
        logic output_invert;
        logic period_duty_swap;
        logic clear_source_select;
    } ctrl1_s;

endpackage : timer_pkg

// File: design/compact_timer.sv
// 10-bit compact timer with compare output, timer and PWM modes
//
// Summary of operation
// RULE_01 - Counter readable as low and high bytes
// RULE_02 - Compare-A value held as two writable bytes
// RULE_03 - Unused high-byte bits read as zero
// RULE_04 - Mode codes: compare, PWM, plain timer
// RULE_05 - Period match or overflow clears; both flags
// RULE_06 - Clear source high: A clears, no P
// RULE_07 - Compare-A zero: run to 3FF, no flag
// RULE_08 - Compare mode pin moves only on A match
// RULE_09 - A match drives pin high, low or toggles
// RULE_10 - Enable rise loads pin initial level
// RULE_11 - Timer mode like compare, pin undriven
// RULE_12 - PWM ignores clear source; swap picks roles
// RULE_13 - Swap zero: period from period value
// RULE_14 - Duty at or above period gives full duty
// RULE_15 - Swap one: compare-A sets period
// RULE_16 - PWM raises both flags on matches
// RULE_17 - PWM level, pin action and invert
// RULE_18 - PWM keeps counting while pin forced
// RULE_19 - Period value meets counter's top three bits
// RULE_20 - Enable rise zeroes counter; off holds value
// RULE_21 - Compare pin actions: none, low, high, toggle
// RULE_22 - PWM pin actions: inactive, active, waveform
// RULE_23 - Counter advances once per selected tick
`timescale 1ns/1ps

module compact_timer (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Register port
    input timer_pkg::reg_req_s i_bus,
    output logic [timer_pkg::DATA_W-1:0] o_rdata,
    // External counter clock pin
    input wire logic i_ext_clock,
    // Timer output pin
    output logic o_pin,
    output logic o_pin_oe,
    // Match flags
    output logic o_match_a_flag,
    output logic o_match_p_flag
);
    import timer_pkg::*;

    ctrl0_s ctrl0;
    ctrl1_s ctrl1;
    logic [CNT_W-1:0] compare_a_value;
    logic [CNT_W-1:0] count;
    logic enable_q;
    logic [5:0] prescale;
    logic [10:0] sub_count;
    logic sub_tick;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic pin_state;
    logic sel_tick;
    logic enable_rise;
    logic count_tick;
    logic [LEN_W-1:0] inc;
    logic match_a;
    logic match_p;
    logic overflow;
    logic clear_now;
    logic set_a;
    logic set_p;
    logic clr_a;
    logic clr_p;
    logic is_pwm;
    logic [1:0] mode;
    logic [1:0] action;
    logic [LEN_W-1:0] period_len;
    logic [LEN_W-1:0] duty;
    logic pwm_active;
    logic pwm_level;
    logic next_pin_state;
    logic [DATA_W-1:0] next_rdata;
    logic forced_level;

    assign mode = {ctrl1.mode_select_hi, ctrl1.mode_select_lo};
    assign action = {ctrl1.pin_action_hi, ctrl1.pin_action_lo};
    assign is_pwm = (mode == MODE_PWM); // RULE_04
    assign forced_level = ctrl1.output_initial_level ^ ctrl1.output_invert;

    // Register writes; mode bits should only change while off
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl0 <= CTRL_RESET;
            ctrl1 <= CTRL_RESET;
            compare_a_value <= COUNT_ZERO;
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                ADDR_CTRL0: ctrl0 <= i_bus.wdata;
                ADDR_CTRL1: ctrl1 <= i_bus.wdata;
                ADDR_CMP_A_LOW: compare_a_value[7:0] <= i_bus.wdata; // RULE_02
                ADDR_CMP_A_HIGH: compare_a_value[9:8] <= i_bus.wdata[1:0]; // RULE_02
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = DATA_ZERO;
        case (i_bus.addr)
            ADDR_CTRL0: next_rdata = ctrl0;
            ADDR_CTRL1: next_rdata = ctrl1;
            ADDR_COUNT_LOW: next_rdata = count[7:0]; // RULE_01
            ADDR_COUNT_HIGH: next_rdata = {HIGH_PAD, count[9:8]}; // RULE_03
            ADDR_CMP_A_LOW: next_rdata = compare_a_value[7:0];
            ADDR_CMP_A_HIGH: next_rdata = {HIGH_PAD, compare_a_value[9:8]}; // RULE_03
            ADDR_FLAGS: next_rdata = {HIGH_PAD, o_match_p_flag, o_match_a_flag};
            default: next_rdata = DATA_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= DATA_ZERO;
        end else if (i_bus.rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= DATA_ZERO;
        end
    end

    // External clock pin synchroniser, edge taken after second stage
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= i_ext_clock;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // Free-running prescaler; fast clock taken as the system clock
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            prescale <= 6'h00;
        end else begin
            prescale <= prescale + PRESCALE_ONE;
        end
    end

    // Sub clock divider gives a one-cycle enable
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sub_count <= SUB_ZERO;
            sub_tick <= 1'b0;
        end else if (sub_count == SUB_LAST) begin
            sub_count <= SUB_ZERO;
            sub_tick <= 1'b1;
        end else begin
            sub_count <= sub_count + SUB_ONE;
            sub_tick <= 1'b0;
        end
    end

    // Counter clock selection
    always_comb begin
        case (ctrl0.clock_select)
            CKS_SYS_DIV4: sel_tick = ((prescale & DIV4_MASK) == DIV4_MASK);
            CKS_SYS: sel_tick = 1'b1;
            CKS_FAST_DIV16: sel_tick = ((prescale & DIV16_MASK) == DIV16_MASK);
            CKS_FAST_DIV64: sel_tick = ((prescale & DIV64_MASK) == DIV64_MASK);
            CKS_SUB_A, CKS_SUB_B: sel_tick = sub_tick;
            CKS_EXT_RISE: sel_tick = ext_sync & ~ext_prev;
            CKS_EXT_FALL: sel_tick = ~ext_sync & ext_prev;
            default: sel_tick = 1'b0;
        endcase
    end

    // Enable edge and gated count tick
    assign enable_rise = ctrl0.module_enable & ~enable_q;
    assign count_tick = ctrl0.module_enable & ~ctrl0.pause & sel_tick & ~enable_rise; // RULE_23

    // Comparators look at the value the counter is about to take
    assign inc = {1'b0, count} + {1'b0, COUNT_ONE};
    assign match_a = count_tick && (compare_a_value != COUNT_ZERO)
                     && (inc[9:0] == compare_a_value); // RULE_07
    assign match_p = count_tick && (ctrl0.period_compare_value != PERIOD_ZERO)
                     && (inc[9:7] == ctrl0.period_compare_value)
                     && (inc[6:0] == PERIOD_LOW_ZERO); // RULE_19
    assign overflow = count_tick && (count == COUNT_MAX);

    // Clear source: PWM uses the swap bit, other modes the selector
    always_comb begin
        if (is_pwm) begin
            clear_now = ctrl1.period_duty_swap ? match_a : match_p; // RULE_12
        end else begin
            clear_now = ctrl1.clear_source_select ? match_a : match_p; // RULE_05 RULE_06
        end
    end

    // Flag sources; P blocked when A clears outside PWM
    assign set_a = match_a; // RULE_16
    assign set_p = (match_p | (overflow & (ctrl0.period_compare_value == PERIOD_ZERO)))
                   & (is_pwm | ~ctrl1.clear_source_select); // RULE_05 RULE_06 RULE_16
    assign clr_a = i_bus.wr && (i_bus.addr == ADDR_FLAGS) && i_bus.wdata[FLAG_A_BIT];
    assign clr_p = i_bus.wr && (i_bus.addr == ADDR_FLAGS) && i_bus.wdata[FLAG_P_BIT];

    // Enable history for edge detection
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= ctrl0.module_enable;
        end
    end

    // Counter; overflow wraps through the 10-bit add
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= COUNT_ZERO;
        end else if (enable_rise) begin
            count <= COUNT_ZERO; // RULE_20
        end else if (count_tick) begin
            count <= clear_now ? COUNT_ZERO : inc[CNT_W-1:0]; // RULE_05 RULE_18
        end
    end

    // Sticky flags, write one clears, a new event wins over the clear
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_match_a_flag <= 1'b0;
            o_match_p_flag <= 1'b0;
        end else begin
            o_match_a_flag <= (o_match_a_flag & ~clr_a) | set_a;
            o_match_p_flag <= (o_match_p_flag & ~clr_p) | set_p;
        end
    end

    // PWM period and duty lengths in counter clocks
    always_comb begin
        if (ctrl0.period_compare_value == PERIOD_ZERO) begin
            period_len = FULL_PERIOD;
        end else begin
            period_len = {ctrl0.period_compare_value, PERIOD_LOW_ZERO, 1'b0} >> 1;
        end
        duty = ctrl1.period_duty_swap ? period_len : {1'b0, compare_a_value}; // RULE_13 RULE_15
    end

    // Duty at or above period keeps the compare true all period
    assign pwm_active = ({1'b0, count} < duty); // RULE_14

    // PWM pin level before inversion
    always_comb begin
        case (action)
            ACT_FORCE_INACTIVE: pwm_level = ~ctrl1.output_initial_level; // RULE_22
            ACT_FORCE_ACTIVE: pwm_level = ctrl1.output_initial_level; // RULE_22
            ACT_WAVEFORM: pwm_level = pwm_active ? ctrl1.output_initial_level
                                                 : ~ctrl1.output_initial_level; // RULE_17
            default: pwm_level = ~ctrl1.output_initial_level;
        endcase
    end

    // Compare-mode pin state, loaded on enable rise, then moved only by A matches
    always_comb begin
        next_pin_state = pin_state;
        if (enable_rise) begin
            next_pin_state = ctrl1.output_initial_level; // RULE_10
        end else if (match_a && (mode == MODE_COMPARE)) begin // RULE_08
            case (action)
                ACT_LOW: next_pin_state = 1'b0; // RULE_21
                ACT_HIGH: next_pin_state = 1'b1; // RULE_21
                ACT_TOGGLE: next_pin_state = ~pin_state; // RULE_09
                default: next_pin_state = pin_state; // RULE_09
            endcase
        end
    end

    // Pin state register
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_state <= 1'b0;
        end else begin
            pin_state <= next_pin_state;
        end
    end

    // Output pin; timer mode leaves the pin free for other uses
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pin <= 1'b0;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin <= (is_pwm ? pwm_level : pin_state) ^ ctrl1.output_invert; // RULE_17
            o_pin_oe <= (mode == MODE_COMPARE) || is_pwm; // RULE_11
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    property p_high_zero;
        (i_bus.rd && i_bus.addr == ADDR_COUNT_HIGH)
            |=> ((o_rdata & HIGH_UNUSED_MASK) == DATA_ZERO);
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high byte upper bits set"); // RULE_03

    property p_count_low;
        (i_bus.rd && i_bus.addr == ADDR_COUNT_LOW) |=> (o_rdata == $past(next_rdata))
            ##1 (o_rdata == DATA_ZERO || $past(i_bus.rd));
    endproperty
    a_count_low: assert property (p_count_low) else $error("count low read wrong"); // RULE_01

    property p_enable_zero;
        $rose(ctrl0.module_enable) |-> ##1 (count == COUNT_ZERO);
    endproperty
    a_enable_zero: assert property (p_enable_zero) else $error("counter not zeroed"); // RULE_20

    property p_no_p_flag;
        (!is_pwm && ctrl1.clear_source_select && !o_match_p_flag) |=> !o_match_p_flag;
    endproperty
    a_no_p_flag: assert property (p_no_p_flag) else $error("P flag with A clear"); // RULE_06

    property p_pin_hold;
        (mode == MODE_COMPARE && !match_a && !enable_rise) |=> (pin_state == $past(pin_state));
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin moved without A match"); // RULE_08

    property p_timer_free;
        (mode == MODE_TIMER) |=> !o_pin_oe;
    endproperty
    a_timer_free: assert property (p_timer_free) else $error("timer pin driven"); // RULE_11

    property p_force_active;
        (is_pwm && action == ACT_FORCE_ACTIVE) |=> (o_pin == $past(forced_level));
    endproperty
    a_force_active: assert property (p_force_active) else $error("forced level wrong"); // RULE_22

    property p_advance;
        (count_tick && !clear_now) |=> (count == $past(count) + COUNT_ONE);
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not advance"); // RULE_23

    property p_pwm_period;
        (is_pwm && !ctrl1.period_duty_swap && match_p) |=> (count == COUNT_ZERO) && o_match_p_flag;
    endproperty
    a_pwm_period: assert property (p_pwm_period) else $error("PWM period clear missed"); // RULE_13

    property p_pwm_swap;
        (is_pwm && ctrl1.period_duty_swap && match_a) |=> (count == COUNT_ZERO) && o_match_a_flag;
    endproperty
    a_pwm_swap: assert property (p_pwm_swap) else $error("PWM swapped clear missed"); // RULE_15

    property p_cmpa_hi;
        (i_bus.rd && i_bus.addr == ADDR_CMP_A_HIGH)
            |=> ((o_rdata & HIGH_UNUSED_MASK) == DATA_ZERO);
    endproperty
    a_cmpa_hi: assert property (p_cmpa_hi) else $error("compare high bits set"); // RULE_03

    // Pin reaches the initial level two edges after the enable rise
    property p_enable_pin;
        (enable_rise && mode == MODE_COMPARE) |=> ##1 (o_pin == $past(forced_level, 2));
    endproperty
    a_enable_pin: assert property (p_enable_pin) else $error("pin not initial level"); // RULE_10

    property p_overflow_p;
        (!is_pwm && !ctrl1.clear_source_select && overflow
            && ctrl0.period_compare_value == PERIOD_ZERO) |=> o_match_p_flag;
    endproperty
    a_overflow_p: assert property (p_overflow_p) else $error("no P flag on overflow"); // RULE_05

    property p_zero_no_a;
        (compare_a_value == COUNT_ZERO && !o_match_a_flag) |=> !o_match_a_flag;
    endproperty
    a_zero_no_a: assert property (p_zero_no_a) else $error("A flag with zero compare"); // RULE_07

    c_compare_toggle: cover property ((mode == MODE_COMPARE) && match_a && action == ACT_TOGGLE);
    c_pwm_wrap: cover property (is_pwm && clear_now ##1 (count == COUNT_ZERO));
    c_flag_race: cover property (set_a && clr_a);
    c_overflow: cover property (overflow && !is_pwm);

endmodule : compact_timer

// File: sim/compact_timer_test.sv
// Self-checking bench for the compact timer through its register port
`timescale 1ns/1ps

module compact_timer_test;
    import timer_pkg::*;

    logic i_clock;
    logic i_resetn;
    reg_req_s bus;
    logic [DATA_W-1:0] o_rdata;
    logic i_ext_clock;
    logic o_pin;
    logic o_pin_oe;
    logic o_match_a_flag;
    logic o_match_p_flag;
    int n_fail;
    int check_count;
    int cycles = 0;
    int hi;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic [1:0] act;
    logic oc;
    logic exp_pin;

    // PWM cases: control, compare A, period value, window length, high cycles per window
    logic [7:0] pw_c1 [10] = '{8'hA8, 8'hAC, 8'hA0, 8'h98, 8'h88, 8'hA9, 8'hA8, 8'hA8,
        8'hAA, 8'hAA};
    logic [9:0] pw_a [10] = '{10'h020, 10'h020, 10'h020, 10'h020, 10'h020, 10'h020,
        10'h040, 10'h0C8, 10'h0C8, 10'h0C8};
    logic [2:0] pw_p [10] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h1, 3'h0};
    int pw_len [10] = '{256, 256, 256, 256, 256, 256, 512, 256, 400, 400};
    int pw_hi [10] = '{64, 192, 192, 256, 0, 64, 128, 256, 256, 400};

    compact_timer dut (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_bus(bus),
        .o_rdata(o_rdata),
        .i_ext_clock(i_ext_clock),
        .o_pin(o_pin),
        .o_pin_oe(o_pin_oe),
        .o_match_a_flag(o_match_a_flag),
        .o_match_p_flag(o_match_p_flag)
    );

    // 50 MHz system clock
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    // Hang guard, about five times the expected run
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(posedge i_clock);
    endtask : ticks

    // One-cycle write strobe, changed just after an edge
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_clock);
        bus.wr <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_clock);
        bus.rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd_reg

    // Mode and pin action only change while off, so switch off first
    task automatic setup(input logic [7:0] c1, input logic [7:0] c0, input logic [9:0] cmpa);
        wr_reg(ADDR_CTRL0, c0 & 8'hF7);
        wr_reg(ADDR_CTRL1, c1);
        wr_reg(ADDR_CMP_A_LOW, cmpa[7:0]);
        wr_reg(ADDR_CMP_A_HIGH, {6'h00, cmpa[9:8]});
        wr_reg(ADDR_FLAGS, 8'h03);
        wr_reg(ADDR_CTRL0, c0);
    endtask : setup

    task automatic measure(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge i_clock);
            #1;
            if (o_pin === 1'b1) h++;
        end
    endtask : measure

    // Non-PWM run: initial pin level, then flags and pin after the wait
    task automatic comp_case(input logic [7:0] c1, input logic [7:0] c0, input logic [9:0] cmpa,
                             input int wt, input logic pin, input logic a, input logic p);
        logic drive;
        drive = (c1[7:6] == MODE_COMPARE);
        setup(c1, c0, cmpa);
        ticks(3);
        if (drive) check("initial_pin", o_pin, c1[3]);
        ticks(wt - 3);
        check("pin_enable", o_pin_oe, drive);
        if (drive) check("pin_level", o_pin, pin);
        check("match_a_flag", o_match_a_flag, a);
        check("match_p_flag", o_match_p_flag, p);
    endtask : comp_case

    task automatic test_done();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        i_resetn = 1'b0;
        bus = '0;
        i_ext_clock = 1'b0;
        n_fail = 0;
        check_count = 0;
        ticks(3);
        i_resetn <= 1'b1;
        // Every offset reads zero after reset, the unmapped one included
        for (int k = 0; k < 8; k++) begin
            rd_reg(3'(k), rd0);
            check("reset_read", rd0, 10'h000);
        end
        // Compare A bytes hold; count bytes ignore writes
        wr_reg(ADDR_CMP_A_LOW, 8'hA5);
        wr_reg(ADDR_CMP_A_HIGH, 8'hFF);
        wr_reg(ADDR_COUNT_LOW, 8'h5A);
        wr_reg(ADDR_COUNT_HIGH, 8'hFF);
        rd_reg(ADDR_CMP_A_LOW, rd0);
        check("cmp_a_low", rd0, 10'h0A5);
        rd_reg(ADDR_CMP_A_HIGH, rd0);
        check("cmp_a_high", rd0, 10'h003);
        rd_reg(ADDR_COUNT_LOW, rd0);
        check("count_low_ro", rd0, 10'h000);
        // Every pin action against both initial levels, A clears past a P match
        for (int k = 0; k < 8; k++) begin
            act = 2'(k >> 1);
            oc = k[0];
            exp_pin = (act == ACT_NONE) ? oc : (act == ACT_LOW) ? 1'b0 :
                      (act == ACT_HIGH) ? 1'b1 : ~oc;
            comp_case({2'b00, act, oc, 3'b001}, 8'h19, 10'h0C8, 250, exp_pin,
                      1'b1, 1'b0);
        end
        comp_case(8'h20, 8'h19, 10'h005, 300, 1'b1, 1'b1, 1'b1);
        rd_reg(ADDR_COUNT_LOW, rd0);
        check("count_below_period", rd0 & 8'h80, 10'h000);
        rd_reg(ADDR_COUNT_HIGH, rd0);
        check("count_high_period", rd0, 10'h000);
        comp_case(8'h30, 8'h19, 10'h000, 300, 1'b0, 1'b0, 1'b1);
        comp_case(8'h00, 8'h18, 10'h005, 1100, 1'b0, 1'b1, 1'b1);
        // Flag register reads both flags; writing one clears only A
        rd_reg(ADDR_FLAGS, rd0);
        check("flags_read", rd0, 10'h003);
        wr_reg(ADDR_FLAGS, 8'h01);
        rd_reg(ADDR_FLAGS, rd0);
        check("flag_a_cleared", rd0, 10'h002);
        comp_case(8'h31, 8'h19, 10'h000, 1100, 1'b0, 1'b0, 1'b0);
        // Switching off freezes the count; switching on zeroes it
        wr_reg(ADDR_CTRL0, 8'h11);
        rd_reg(ADDR_COUNT_LOW, rd0);
        rd_reg(ADDR_COUNT_HIGH, rd1);
        check("high_unused", rd1 & 8'hFC, 10'h000);
        ticks(20);
        rd_reg(ADDR_COUNT_LOW, rd1);
        check("count_held", rd1, rd0);
        wr_reg(ADDR_CTRL0, 8'h19);
        rd_reg(ADDR_COUNT_LOW, rd0);
        check("count_restart", rd0 & 8'hF8, 10'h000);
        rd_reg(ADDR_COUNT_HIGH, rd0);
        check("count_restart_high", rd0, 10'h000);
        comp_case(8'hF1, 8'h19, 10'h032, 100, 1'b0, 1'b1, 1'b0);
        // Undefined mode counts like compare mode but leaves the pin free
        comp_case(8'h51, 8'h19, 10'h032, 100, 1'b0, 1'b1, 1'b0);
        // External rising-edge clock counts; pause then holds the count
        setup(8'h00, 8'h68, 10'h000);
        for (int k = 0; k < 15; k++) begin
            if (k == 10) begin
                ticks(6);
                wr_reg(ADDR_CTRL0, 8'hE8);
            end
            i_ext_clock <= 1'b1;
            ticks(4);
            i_ext_clock <= 1'b0;
            ticks(4);
        end
        ticks(6);
        rd_reg(ADDR_COUNT_LOW, rd0);
        check("ext_count", rd0, 10'h00A);
        // PWM levels, forcing, swap and full duty, counted over whole periods
        for (int k = 0; k < 10; k++) begin
            setup(pw_c1[k], {5'h03, pw_p[k]}, pw_a[k]);
            ticks(pw_len[k]);
            measure(pw_len[k], hi);
            check("pwm_hi", 10'(hi), 10'(pw_hi[k]));
            if (k < 6) begin
                check("pwm_flag_a", o_match_a_flag, 1'b1);
                check("pwm_flag_p", o_match_p_flag, 1'b1);
            end
        end
        test_done();
    end

endmodule : compact_timer_test
